// File: logic/gpa_defines.svh
// gpa_defines.svh: offsets, field positions, reset values for the gpio alarm pin block
// assumes inclusion by bare name from logic/ files
`ifndef GPA_DEFINES_SVH
`define GPA_DEFINES_SVH
// per-pin config word at index n: byte offset CFG_BASE + 4*n
`define GPA_CFG_BASE 8'h00
// pin output level register, one bit per pin
`define GPA_OUT_LVL 8'h40
// synchronized pin input levels, read only
`define GPA_IN_LVL 8'h44
// sticky status read, write one to clear
`define GPA_STICKY 8'h48
// alert enable mask over sticky bits
`define GPA_ALERT_EN 8'h4C
// live source status, read only
`define GPA_LIVE 8'h50
// upper words of the sticky, alert enable and live vectors (sources 32 and up)
`define GPA_STICKY_HI 8'h54
`define GPA_ALERT_EN_HI 8'h58
`define GPA_LIVE_HI 8'h5C
// config field positions
`define GPA_F_MODE_LO 0
`define GPA_F_MODE_HI 2
`define GPA_F_SEL_LO 4
`define GPA_F_SEL_HI 7
`define GPA_F_STICKY 8
`define GPA_F_INV 9
`define GPA_CFG_RST 32'h0000_0000
`endif

// File: logic/gpa_pkg.sv
// gpa_pkg: types for the gpio alarm pin block
// assumes gpa_defines.svh alongside
package gpa_pkg;
   typedef enum logic [2:0] {
      GPA_M_INPUT = 3'h0,
      GPA_M_OUTPUT = 3'h1,
      GPA_M_SIG_LOSS = 3'h2,
      GPA_M_LOCK_LOSS = 3'h3,
      GPA_M_HOLDOVER = 3'h4,
      GPA_M_ALERT = 3'h5
   } gpa_mode_e;
   typedef enum logic [1:0] {
      GPA_RS_RESET = 2'b01,
      GPA_RS_RUN = 2'b10
   } gpa_rst_state_e;
endpackage : gpa_pkg

// File: logic/gpa_sticky.sv
// gpa_sticky: change-detect sticky bits with write-one-to-clear
// assumes sources already synchronous to clk_sys
`timescale 1ns/1ps
module gpa_sticky #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] src,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] sticky
);
   logic [W-1:0] prev_q;
   logic [W-1:0] sticky_q;
   logic primed_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         primed_q <= 1'b0;
      end else begin
         primed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= src;
      end
   end

   // set beats clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sticky_q <= '0;
      end else begin
         sticky_q <= (sticky_q & ~clr) | ((src ^ prev_q) & {W{primed_q}});
      end
   end

   assign sticky = sticky_q;
endmodule : gpa_sticky

// File: logic/gpa_pins.sv
// gpa_pins: sixteen configurable gpio pins with alarm modes
// assumes sync monitor/pll status inputs and a reset-done level on clk_sys
//
// Contract
// - sixteen pins, each with its own config register selecting mode.
// - any pin may take any function on any selected source.
// - configured mode applies only after reset sequence completes.
// - input mode reflects pin level in a readable register; default mode.
// - output mode drives the pin from a software-written level register.
// - identically configured pins show identical outputs, except in output mode, where each pin drives its own out_lvl_q bit.
// - signal-loss mode is active high alarm of selected monitor, optional invert.
// - signal-loss output follows the monitor directly, unlatched.
// - live lock-loss drives high while selected pll is unlocked.
// - sticky lock-loss goes high on any lock change and stays high.
// - sticky indication may be inverted so low signals the change.
// - sticky indication holds until software writes its clear bit.
// - holdover mode reports holdover of a configured pll channel.
// - source of each alarm pin is chosen by configuration.
// - live holdover high while in holdover; sticky on entry or exit.
// - alert mode is OR of enabled sticky bits, invertible.
// - each sticky bit sets on any change of its condition.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "gpa_defines.svh"
module gpa_pins
   import gpa_pkg::*;
#(
   parameter int NPIN = 16,
   parameter int NSRC = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reset_done,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic [NSRC-1:0] signal_loss,
   input wire logic [NSRC-1:0] digital_pll_unlock,
   input wire logic [NSRC-1:0] analog_pll_unlock,
   input wire logic [NSRC-1:0] digital_pll_holdover,
   input wire logic [NPIN-1:0] gpio_in,
   output logic [NPIN-1:0] gpio_out,
   output logic [NPIN-1:0] gpio_oe
);
   // source layout inside the live/sticky vector: 3 groups of NSRC
   localparam int NS = 3 * NSRC;

   logic [31:0] cfg_q [NPIN];
   logic [NPIN-1:0] out_lvl_q;
   logic [NPIN-1:0] in_s1_q;
   logic [NPIN-1:0] in_s2_q;
   logic [NPIN-1:0] in_lvl_q;
   logic [NS-1:0] alert_en_q;
   logic [NS-1:0] live;
   logic [NS-1:0] sticky;
   logic [NS-1:0] clr;
   logic [NPIN-1:0] pin_d;
   logic [NPIN-1:0] oe_d;
   logic [NPIN-1:0] pin_q;
   logic [NPIN-1:0] oe_q;
   logic [31:0] rdata_q;
   logic alert;
   logic [63:0] sticky_w;
   logic [63:0] live_w;
   logic [63:0] en_w;
   gpa_rst_state_e rs_q;

   assign live = {digital_pll_holdover, digital_pll_unlock | analog_pll_unlock, signal_loss};

   // clear pulse for sticky bits, write one to clear
   // vectors wider than the bus are split over a low and a high word
   assign clr = NS'({(wr_en && addr == `GPA_STICKY_HI) ? wdata : 32'h0000_0000,
      (wr_en && addr == `GPA_STICKY) ? wdata : 32'h0000_0000});
   assign sticky_w = 64'(sticky);
   assign live_w = 64'(live);
   assign en_w = 64'(alert_en_q);

   gpa_sticky #(.W(NS)) u_sticky (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .src(live),
      .clr(clr),
      .sticky(sticky)
   );

   assign alert = |(sticky & alert_en_q);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rs_q <= GPA_RS_RESET;
      end else begin
         case (rs_q)
            GPA_RS_RESET: if (reset_done) rs_q <= GPA_RS_RUN;
            GPA_RS_RUN: rs_q <= GPA_RS_RUN;
            default: rs_q <= GPA_RS_RESET;
         endcase
      end
   end

   // two-stage synchronizer, then stored level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         in_s1_q <= '0;
         in_s2_q <= '0;
         in_lvl_q <= '0;
      end else begin
         in_s1_q <= gpio_in;
         in_s2_q <= in_s1_q;
         in_lvl_q <= in_s2_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NPIN; i++) begin
            cfg_q[i] <= `GPA_CFG_RST;
         end
      end else if (wr_en && addr < 8'(`GPA_CFG_BASE + 4 * NPIN) && addr[1:0] == 2'b00) begin
         cfg_q[addr[5:2]] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_lvl_q <= '0;
      end else if (wr_en && addr == `GPA_OUT_LVL) begin
         out_lvl_q <= wdata[NPIN-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alert_en_q <= '0;
      end else if (wr_en && addr == `GPA_ALERT_EN) begin
         alert_en_q <= NS'({en_w[63:32], wdata});
      end else if (wr_en && addr == `GPA_ALERT_EN_HI) begin
         alert_en_q <= NS'({wdata, en_w[31:0]});
      end
   end

   // per-pin mode mux; output depends on config, shared sources and, in output mode, the pin's own out_lvl_q bit
   generate
      for (genvar p = 0; p < NPIN; p++) begin : g_pin
         gpa_mode_e mode;
         logic [3:0] sel;
         logic stk;
         logic inv;
         logic raw;
         logic oe_l;
         logic pin_l;
         assign mode = gpa_mode_e'(cfg_q[p][`GPA_F_MODE_HI:`GPA_F_MODE_LO]);
         assign sel = cfg_q[p][`GPA_F_SEL_HI:`GPA_F_SEL_LO];
         assign stk = cfg_q[p][`GPA_F_STICKY];
         assign inv = cfg_q[p][`GPA_F_INV];
         always_comb begin
            raw = 1'b0;
            oe_l = 1'b1;
            case (mode)
               GPA_M_INPUT: oe_l = 1'b0;
               GPA_M_OUTPUT: raw = out_lvl_q[p];
               GPA_M_SIG_LOSS: raw = live[sel];
               GPA_M_LOCK_LOSS: raw = stk ? sticky[NSRC + sel] : live[NSRC + sel];
               GPA_M_HOLDOVER: raw = stk ? sticky[2*NSRC + sel] : live[2*NSRC + sel];
               GPA_M_ALERT: raw = alert;
               default: oe_l = 1'b0;
            endcase
            pin_l = raw ^ inv;
            if (rs_q != GPA_RS_RUN) begin
               oe_l = 1'b0;
               pin_l = 1'b0;
            end
         end
         assign oe_d[p] = oe_l;
         assign pin_d[p] = pin_l;
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= '0;
         oe_q <= '0;
      end else begin
         pin_q <= pin_d;
         oe_q <= oe_d;
      end
   end

   assign gpio_out = pin_q;
   assign gpio_oe = oe_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (rd_en) begin
         rdata_q <= '0;
         if (addr < 8'(`GPA_CFG_BASE + 4 * NPIN)) begin
            rdata_q <= cfg_q[addr[5:2]];
         end else begin
            case (addr)
               `GPA_OUT_LVL: rdata_q <= 32'(out_lvl_q);
               `GPA_IN_LVL: rdata_q <= 32'(in_lvl_q);
               `GPA_STICKY: rdata_q <= sticky_w[31:0];
               `GPA_STICKY_HI: rdata_q <= sticky_w[63:32];
               `GPA_ALERT_EN: rdata_q <= en_w[31:0];
               `GPA_ALERT_EN_HI: rdata_q <= en_w[63:32];
               `GPA_LIVE: rdata_q <= live_w[31:0];
               `GPA_LIVE_HI: rdata_q <= live_w[63:32];
               default: rdata_q <= '0;
            endcase
         end
      end else begin
         rdata_q <= '0;
      end
   end

   assign rdata = rdata_q;

   // checks
   property p_sticky_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      (sticky[NSRC + 7] && clr[NSRC + 7] == 1'b0) |=> sticky[NSRC + 7];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky dropped");

   property p_sticky_set;
      @(posedge clk_sys) disable iff (!rst_n)
      ($changed(live[NSRC + 7]) && $past(rst_n)) |=> sticky[NSRC + 7];
   endproperty
   a_sticky_set: assert property (p_sticky_set) else $error("sticky not set");

   property p_sync;
      @(posedge clk_sys) disable iff (!rst_n)
      ##3 (in_lvl_q == $past(gpio_in, 3));
   endproperty
   a_sync: assert property (p_sync) else $error("input sync latency");

   property p_reset_quiet;
      @(posedge clk_sys) disable iff (!rst_n)
      (rs_q == GPA_RS_RESET) |=> (gpio_oe == '0);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("pin driven in reset");

   property p_out_mode;
      @(posedge clk_sys) disable iff (!rst_n)
      (rs_q == GPA_RS_RUN && cfg_q[0][2:0] == 3'h1 && !cfg_q[0][9]) |=> gpio_out[0] == $past(out_lvl_q[0]);
   endproperty
   a_out_mode: assert property (p_out_mode) else $error("output level wrong");

   property p_input_mode;
      @(posedge clk_sys) disable iff (!rst_n)
      (cfg_q[0][2:0] == 3'h0) |=> !gpio_oe[0];
   endproperty
   a_input_mode: assert property (p_input_mode) else $error("input pin driven");

   property p_sigloss;
      @(posedge clk_sys) disable iff (!rst_n)
      (rs_q == GPA_RS_RUN && cfg_q[2][2:0] == 3'h2)
         |=> gpio_out[2] == ($past(live[cfg_q[2][7:4]]) ^ $past(cfg_q[2][9]));
   endproperty
   a_sigloss: assert property (p_sigloss) else $error("signal loss mismatch");

   property p_alert;
      @(posedge clk_sys) disable iff (!rst_n)
      (rs_q == GPA_RS_RUN && cfg_q[9][2:0] == 3'h5)
         |=> gpio_out[9] == ($past(alert) ^ $past(cfg_q[9][9]));
   endproperty
   a_alert: assert property (p_alert) else $error("alert mismatch");

   property p_same;
      @(posedge clk_sys) disable iff (!rst_n)
      (cfg_q[2] == cfg_q[3] && cfg_q[2][2:0] != 3'h1) |=> gpio_out[2] == gpio_out[3];
   endproperty
   a_same: assert property (p_same) else $error("identical pins differ");

   c_run: cover property (@(posedge clk_sys) rs_q == GPA_RS_RUN);
   c_sticky: cover property (@(posedge clk_sys) |sticky);
   c_clear: cover property (@(posedge clk_sys) |(clr & sticky));
   c_alert: cover property (@(posedge clk_sys) alert);
endmodule : gpa_pins

// File: dv/gpa_board.sv
// gpa_board: board-side drivers on the sixteen gpio pins
// assumes each pin is driven by the device while oe is high, else by the board
`timescale 1ns/1ps
module gpa_board (
   input wire logic [15:0] gpio_out,
   input wire logic [15:0] gpio_oe,
   input wire logic [15:0] ext_lvl,
   output logic [15:0] gpio_in
);
   // resolved wire level fed back to the device input
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
endmodule : gpa_board

// File: dv/tb.sv
// tb: register-driven checks of the gpio alarm pin block
// assumes gpa_pins, gpa_pkg and the board model are compiled first
`timescale 1ns/1ps
`include "gpa_defines.svh"
module tb
   import gpa_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reset_done = 1'b0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic [15:0] sl = 16'h0000, du = 16'h0000, au = 16'h0000, ho = 16'h0000;
   logic [15:0] ext = 16'h0000;
   logic [15:0] gout, goe, gin;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;

   initial forever #2.5 clk_sys = ~clk_sys;

   gpa_pins i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reset_done(reset_done), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .signal_loss(sl),
      .digital_pll_unlock(du), .analog_pll_unlock(au), .digital_pll_holdover(ho),
      .gpio_in(gin), .gpio_out(gout), .gpio_oe(goe));
   gpa_board i_board (.gpio_out(gout), .gpio_oe(goe), .ext_lvl(ext), .gpio_in(gin));

   task tally_and_finish;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         $display("unexpected at %0t: run too long", $time);
         tally_and_finish;
      end
   end

   function automatic logic [31:0] cfg(gpa_mode_e m, logic [3:0] s, logic st, logic iv);
      return {22'h0, iv, st, s, 1'b0, m};
   endfunction : cfg

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task chk_word(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: word %h not %h", $time, g, e);
      end
   endtask : chk_word

   task chk_pin(input int p, input logic e);
      checks_done++;
      if (goe[p] !== 1'b1 || gout[p] !== e) begin
         failures++;
         $display("unexpected at %0t: pin %0d out %b oe %b", $time, p, gout[p], goe[p]);
      end
   endtask : chk_pin

   task settle;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : settle

   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      wr(8'h00, cfg(GPA_M_OUTPUT, 4'h0, 1'b0, 1'b0));
      wr(`GPA_OUT_LVL, 32'h0000_0001);
      wr(8'h24, cfg(GPA_M_ALERT, 4'h0, 1'b0, 1'b0));
      wr(`GPA_ALERT_EN, 32'h0080_0008);
      settle;
      chk_word({16'h0000, goe}, 32'h0000_0000);
      @(posedge clk_sys);
      reset_done <= 1'b1;
      settle;
      chk_pin(0, 1'b1);
      chk_pin(9, 1'b0);
      $display("test reset_and_output done");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         ext <= (i == 0) ? 16'h5A5A : 16'hA5A5;
         settle;
         rd(`GPA_IN_LVL, rv);
         chk_word(rv & 32'h0000_FC00, (i == 0) ? 32'h0000_5800 : 32'h0000_A400);
      end
      rd(8'hFC, rv);
      chk_word(rv, 32'h0000_0000);
      $display("test input done");
      wr(8'h08, cfg(GPA_M_SIG_LOSS, 4'h3, 1'b0, 1'b0));
      wr(8'h0C, cfg(GPA_M_SIG_LOSS, 4'h3, 1'b0, 1'b0));
      wr(8'h10, cfg(GPA_M_SIG_LOSS, 4'h3, 1'b0, 1'b1));
      @(posedge clk_sys);
      sl[3] <= 1'b1;
      settle;
      chk_pin(2, 1'b1);
      chk_pin(3, 1'b1);
      chk_pin(4, 1'b0);
      @(posedge clk_sys);
      sl[3] <= 1'b0;
      settle;
      chk_pin(2, 1'b0);
      chk_pin(4, 1'b1);
      $display("test signal_loss done");
      wr(8'h14, cfg(GPA_M_LOCK_LOSS, 4'h6, 1'b0, 1'b0));
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         if (i == 0) au[6] <= 1'b1;
         else du[6] <= 1'b1;
         settle;
         chk_pin(5, 1'b1);
         @(posedge clk_sys);
         au[6] <= 1'b0;
         du[6] <= 1'b0;
         settle;
         chk_pin(5, 1'b0);
      end
      $display("test live_lock done");
      wr(8'h18, cfg(GPA_M_LOCK_LOSS, 4'h7, 1'b1, 1'b0));
      wr(8'h1C, cfg(GPA_M_LOCK_LOSS, 4'h7, 1'b1, 1'b1));
      settle;
      chk_pin(6, 1'b0);
      chk_pin(7, 1'b1);
      @(posedge clk_sys);
      du[7] <= 1'b1;
      settle;
      chk_pin(6, 1'b1);
      @(posedge clk_sys);
      du[7] <= 1'b0;
      settle;
      chk_pin(6, 1'b1);
      chk_pin(7, 1'b0);
      chk_pin(9, 1'b1);
      wr(`GPA_STICKY, 32'h0080_0000);
      settle;
      chk_pin(6, 1'b0);
      chk_pin(7, 1'b1);
      chk_pin(9, 1'b1);
      wr(`GPA_STICKY, 32'h0000_0008);
      settle;
      chk_pin(9, 1'b0);
      $display("test sticky_and_alert done");
      wr(8'h20, cfg(GPA_M_HOLDOVER, 4'h2, 1'b0, 1'b0));
      @(posedge clk_sys);
      ho[2] <= 1'b1;
      settle;
      chk_pin(8, 1'b1);
      @(posedge clk_sys);
      ho[2] <= 1'b0;
      settle;
      chk_pin(8, 1'b0);
      rd(`GPA_STICKY_HI, rv);
      chk_word(rv, 32'h0000_0004);
      rd(`GPA_STICKY, rv);
      chk_word(rv, 32'h0040_0000);
      wr(`GPA_STICKY_HI, 32'h0000_0004);
      rd(`GPA_STICKY_HI, rv);
      chk_word(rv, 32'h0000_0000);
      $display("test holdover done");
      tally_and_finish;
   end
endmodule : tb
